/* design/jdb_ctrl.sv */
// Jog command and external DC brake control for the motor drive.
// How it works
// - Jog output frequency is clamped to ten hertz at most.
// - While jogging the output follows the jog frequency setting.
// - Jog starts by stepping straight to its frequency, no ramp.
// - A jog step above the safe step size raises a trip.
// - Modes 0-2 ignore jog while running, 3-5 interrupt; 0 and 3 coast.
// - Modes 1 and 4 end a jog with a normal deceleration.
// - Modes 2 and 5 end a jog with DC braking for one cycle, longer only while the brake terminal is held.
// - Jog asserted before any direction input turns the output off.
// - No jog when jog frequency is zero or below start frequency.
// - Terminal with function 6 is the jog request.
// - Terminal with function 7 is the external brake request.
// - Brake terminal asserted enables DC braking.
// - Brake delay 0.0 to 5.0 s is waited before braking in keypad run only; terminal run brakes at once.
// - Brake force 0 to 100 percent sets brake strength.
// - Terminal run: after brake release, ramp back to previous frequency.
// - Keypad run: output stays off after brake release.
// - Keypad run: coast for the delay, then DC brake.
//
// The plain strobed port and the address map were decided locally.
`default_nettype none
module jdb_ctrl
  import jdb_pkg::*;
#(
  parameter int DEBOUNCE_CYC = JDB_DEBOUNCE_CYC,
  parameter int DELAY_UNIT_CYC = JDB_DELAY_UNIT_CYC,
  parameter int NUM_TERM = JDB_NUM_TERM
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic forward_run_input_in,
  input wire logic reverse_run_input_in,
  input wire logic [NUM_TERM-1:0] term_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  output logic irq_out,
  output logic output_on_out,
  output logic brake_on_out,
  output logic [7:0] brake_force_out,
  output logic [15:0] freq_out,
  output logic reverse_out,
  output logic trip_out
);
  jdb_bus_req_t req;
  jdb_drive_t drive_q;
  jdb_state_t state_q;
  jdb_state_t state_d;
  logic [NUM_TERM-1:0] term_lvl;
  logic fwd_lvl;
  logic rev_lvl;
  logic [2:0] jog_mode_code_q;
  logic keypad_src_q;
  logic keypad_run_q;
  logic [15:0] jog_frequency_setting_q;
  logic [15:0] start_frequency_setting_q;
  logic [15:0] run_freq_q;
  logic [7:0] brake_delay_setting_q;
  logic [7:0] brake_force_setting_q;
  logic [8*NUM_TERM-1:0] term_func_q;
  logic [JDB_NUM_EV-1:0] irq_stat_q;
  logic [JDB_NUM_EV-1:0] irq_mask_q;
  logic [JDB_NUM_EV-1:0] ev_set;
  logic [31:0] rdata_q;
  logic jog_req;
  logic ext_brake;
  logic ext_brake_prev_q;
  logic jog_prev_q;
  logic jog_first_q;
  logic dir_run;
  logic run_cmd;
  logic jog_ok;
  logic [15:0] jog_freq;
  logic motor_moving;
  logic tmr_start;
  logic tmr_busy;
  logic tmr_done;
  logic brake_delay_done_q;

  assign req = '{addr: reg_addr_in, wdata: reg_wdata_in, wr: reg_wr_in, rd: reg_rd_in};

  // Terminal filters for the multifunction terminals and run inputs
  genvar gi;
  generate
    for (gi = 0; gi < NUM_TERM; gi++) begin : g_term
      jdb_input_filter #(.SETTLE_CYC(DEBOUNCE_CYC)) u_filt (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .pin_in(term_in[gi]),
        .level_out(term_lvl[gi])
      );
    end
  endgenerate
  jdb_input_filter #(.SETTLE_CYC(DEBOUNCE_CYC)) u_fwd (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .pin_in(forward_run_input_in),
    .level_out(fwd_lvl)
  );
  jdb_input_filter #(.SETTLE_CYC(DEBOUNCE_CYC)) u_rev (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .pin_in(reverse_run_input_in),
    .level_out(rev_lvl)
  );

  // OR of all terminals carrying a given function code
  function automatic logic term_match(input logic [8*NUM_TERM-1:0] funcs, input logic [NUM_TERM-1:0] lvl,
                                      input logic [7:0] code);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < NUM_TERM; i++) begin
      if (funcs[8*i +: 8] == code && lvl[i]) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction : term_match

  assign jog_req = term_match(term_func_q, term_lvl, JDB_FUNC_JOG);
  assign ext_brake = term_match(term_func_q, term_lvl, JDB_FUNC_BRAKE);
  assign dir_run = fwd_lvl | rev_lvl;
  assign run_cmd = keypad_src_q ? keypad_run_q : dir_run;
  assign motor_moving = (state_q == JDB_ST_RUN) || (state_q == JDB_ST_DECEL);

  // Jog frequency clamp and permission check
  assign jog_freq = (jog_frequency_setting_q > JDB_JOG_MAX_FREQ) ? JDB_JOG_MAX_FREQ
                                                                 : jog_frequency_setting_q;
  assign jog_ok = (jog_freq != JDB_ZERO_FREQ) && (jog_freq >= start_frequency_setting_q);

  // Brake delay timer restarts on every brake terminal rising edge
  assign tmr_start = ext_brake && !ext_brake_prev_q;
  jdb_delay_timer #(.UNIT_CYC(DELAY_UNIT_CYC)) u_delay (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .start_in(tmr_start),
    .units_in(brake_delay_setting_q),
    .busy_out(tmr_busy),
    .done_out(tmr_done)
  );

  // Edge history and jog-before-direction tracking
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ext_brake_prev_q <= 1'b0;
      jog_prev_q <= 1'b0;
      jog_first_q <= 1'b0;
      brake_delay_done_q <= 1'b0;
    end else begin
      ext_brake_prev_q <= ext_brake;
      jog_prev_q <= jog_req;
      if (!jog_req) begin
        jog_first_q <= 1'b0;
      end else if (!jog_prev_q && !dir_run) begin
        jog_first_q <= 1'b1;
      end
      if (!ext_brake) begin
        brake_delay_done_q <= 1'b0;
      end else if (tmr_done) begin
        brake_delay_done_q <= 1'b1;
      end
    end
  end

  // Next drive state; brake terminal outranks jog, jog outranks run
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      JDB_ST_IDLE: begin
        if (ext_brake) begin
          state_d = keypad_src_q ? JDB_ST_COAST : JDB_ST_BRAKE;
        end else if (jog_req && jog_first_q && dir_run) begin
          state_d = JDB_ST_OFF;
        end else if (jog_req && dir_run && jog_ok) begin
          state_d = JDB_ST_JOG;
        end else if (run_cmd && !jog_req) begin
          state_d = JDB_ST_RUN;
        end
      end
      JDB_ST_RUN: begin
        if (ext_brake) begin
          state_d = keypad_src_q ? JDB_ST_COAST : JDB_ST_BRAKE;
        end else if (jog_req && !jog_prev_q && jog_mode_code_q >= JDB_JM_INT_COAST && jog_ok) begin
          state_d = JDB_ST_JOG;
        end else if (!run_cmd) begin
          state_d = JDB_ST_DECEL;
        end
      end
      JDB_ST_JOG: begin
        if (ext_brake) begin
          state_d = JDB_ST_BRAKE;
        end else if (!jog_req || !dir_run) begin
          unique case (jog_mode_code_q)
            JDB_JM_IGN_COAST, JDB_JM_INT_COAST: state_d = JDB_ST_IDLE;
            JDB_JM_IGN_DECEL, JDB_JM_INT_DECEL: state_d = JDB_ST_DECEL;
            default: state_d = JDB_ST_BRAKE;
          endcase
        end
      end
      JDB_ST_DECEL: begin
        if (ext_brake) begin
          state_d = JDB_ST_BRAKE;
        end else if (drive_q.freq == JDB_ZERO_FREQ) begin
          state_d = JDB_ST_IDLE;
        end else if (run_cmd && !jog_req) begin
          state_d = JDB_ST_RUN;
        end
      end
      JDB_ST_COAST: begin
        if (!ext_brake) begin
          state_d = JDB_ST_OFF;
        end else if (brake_delay_done_q || tmr_done) begin
          state_d = JDB_ST_BRAKE;
        end
      end
      JDB_ST_BRAKE: begin
        if (!ext_brake && jog_mode_code_q >= JDB_JM_IGN_BRAKE && jog_prev_q) begin
          state_d = JDB_ST_IDLE; // Jog-end brake releases to idle if jog was still held last cycle
        end else if (!ext_brake) begin
          state_d = (!keypad_src_q && dir_run) ? JDB_ST_RUN : JDB_ST_OFF;
        end
      end
      JDB_ST_OFF: begin
        // Output held off until every run, jog and brake command is withdrawn
        if (!run_cmd && !jog_req && !ext_brake && !dir_run) begin
          state_d = JDB_ST_IDLE;
        end
      end
      default: state_d = JDB_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_q <= JDB_ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Output frequency: jog steps, run ramps up, decel ramps down, brake and off hold zero
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      drive_q <= '0;
    end else begin
      drive_q.output_on <= (state_d == JDB_ST_RUN) || (state_d == JDB_ST_JOG) || (state_d == JDB_ST_DECEL)
                           || (state_d == JDB_ST_BRAKE);
      drive_q.brake_on <= (state_d == JDB_ST_BRAKE);
      drive_q.brake_force <= (brake_force_setting_q > JDB_BRK_FORCE_MAX) ? JDB_BRK_FORCE_MAX
                                                                         : brake_force_setting_q;
      unique case (state_d)
        JDB_ST_JOG: drive_q.freq <= jog_freq;
        JDB_ST_RUN: begin
          // Ramp back toward the held run frequency after a brake release
          if (drive_q.freq < run_freq_q) begin
            drive_q.freq <= drive_q.freq + JDB_RAMP_STEP;
          end else begin
            drive_q.freq <= run_freq_q;
          end
        end
        JDB_ST_DECEL: begin
          if (drive_q.freq > JDB_ZERO_FREQ) begin
            drive_q.freq <= drive_q.freq - JDB_RAMP_STEP;
          end
        end
        default: drive_q.freq <= JDB_ZERO_FREQ;
      endcase
      // Trip latches on an unramped step too large for the output stage
      if (state_q != JDB_ST_JOG && state_d == JDB_ST_JOG && jog_freq > JDB_STEP_TRIP_FREQ) begin
        drive_q.trip <= 1'b1;
      end else if (req.wr && req.addr == JDB_REG_STATUS && req.wdata[0]) begin
        drive_q.trip <= 1'b0;
      end
    end
  end

  assign output_on_out = drive_q.output_on && !drive_q.trip;
  assign brake_on_out = drive_q.brake_on && !drive_q.trip;
  assign brake_force_out = drive_q.brake_force;
  assign freq_out = drive_q.trip ? JDB_ZERO_FREQ : drive_q.freq;
  assign reverse_out = rev_lvl && !fwd_lvl;
  assign trip_out = drive_q.trip;

  // Settings written by software; out-of-range mode, brake delay and brake force values are clamped on write
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      jog_mode_code_q <= JDB_JM_IGN_COAST;
      keypad_src_q <= 1'b0;
      keypad_run_q <= 1'b0;
      jog_frequency_setting_q <= JDB_ZERO_FREQ;
      start_frequency_setting_q <= JDB_ZERO_FREQ;
      run_freq_q <= JDB_ZERO_FREQ;
      brake_delay_setting_q <= 8'h00;
      brake_force_setting_q <= 8'h00;
      term_func_q <= '0;
      irq_mask_q <= '0;
    end else if (req.wr) begin
      unique case (req.addr)
        JDB_REG_CTRL: begin
          jog_mode_code_q <= (req.wdata[JDB_CTRL_MODE_LSB +: 3] > JDB_JM_INT_BRAKE) ? JDB_JM_INT_BRAKE
                                                                                    : req.wdata[JDB_CTRL_MODE_LSB +: 3];
          keypad_src_q <= req.wdata[JDB_CTRL_KEYPAD_BIT];
          keypad_run_q <= req.wdata[JDB_CTRL_KEYRUN_BIT];
        end
        JDB_REG_JOG_FREQ: jog_frequency_setting_q <= req.wdata[15:0];
        JDB_REG_START_FREQ: start_frequency_setting_q <= req.wdata[15:0];
        JDB_REG_RUN_FREQ: run_freq_q <= req.wdata[15:0];
        JDB_REG_BRK_DELAY: brake_delay_setting_q <= (req.wdata[7:0] > JDB_BRK_DELAY_MAX) ? JDB_BRK_DELAY_MAX
                                                                                        : req.wdata[7:0];
        JDB_REG_BRK_FORCE: brake_force_setting_q <= (req.wdata[7:0] > JDB_BRK_FORCE_MAX) ? JDB_BRK_FORCE_MAX
                                                                                        : req.wdata[7:0];
        JDB_REG_TERM_FUNC: term_func_q <= (8*NUM_TERM)'(req.wdata); // Bytes past the fourth stay 0
        JDB_REG_IRQ_MASK: irq_mask_q <= req.wdata[JDB_NUM_EV-1:0];
        default: ;
      endcase
    end
  end

  // Sticky events; a new event beats a simultaneous write-one clear
  assign ev_set[JDB_EV_TRIP] = (state_q != JDB_ST_JOG) && (state_d == JDB_ST_JOG) && (jog_freq > JDB_STEP_TRIP_FREQ);
  assign ev_set[JDB_EV_JOG_REJECT] = jog_req && !jog_prev_q && (motor_moving || !jog_ok) &&
                                     (state_d != JDB_ST_JOG);
  assign ev_set[JDB_EV_ORDER_OFF] = (state_q != JDB_ST_OFF) && (state_d == JDB_ST_OFF);
  assign ev_set[JDB_EV_BRAKE] = (state_q != JDB_ST_BRAKE) && (state_d == JDB_ST_BRAKE);
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      irq_stat_q <= '0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~((req.wr && req.addr == JDB_REG_IRQ_STAT) ? req.wdata[JDB_NUM_EV-1:0]
                                                                             : {JDB_NUM_EV{1'b0}})) | ev_set;
    end
  end
  assign irq_out = |(irq_stat_q & irq_mask_q);

  // Read data one cycle after the strobe, zero otherwise and for unmapped addresses
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rdata_q <= '0;
    end else if (!req.rd) begin
      rdata_q <= '0;
    end else begin
      unique case (req.addr)
        JDB_REG_CTRL: rdata_q <= {26'h0, keypad_run_q, keypad_src_q, 1'b0, jog_mode_code_q};
        JDB_REG_JOG_FREQ: rdata_q <= {16'h0, jog_frequency_setting_q};
        JDB_REG_START_FREQ: rdata_q <= {16'h0, start_frequency_setting_q};
        JDB_REG_RUN_FREQ: rdata_q <= {16'h0, run_freq_q};
        JDB_REG_BRK_DELAY: rdata_q <= {24'h0, brake_delay_setting_q};
        JDB_REG_BRK_FORCE: rdata_q <= {24'h0, brake_force_setting_q};
        JDB_REG_STATUS: rdata_q <= {22'h0, tmr_busy, ext_brake, jog_req, rev_lvl, fwd_lvl, state_q, drive_q.trip,
                                    drive_q.brake_on};
        JDB_REG_IRQ_STAT: rdata_q <= {28'h0, irq_stat_q};
        JDB_REG_IRQ_MASK: rdata_q <= {28'h0, irq_mask_q};
        JDB_REG_TERM_FUNC: rdata_q <= 32'(term_func_q);
        JDB_REG_OUT_FREQ: rdata_q <= {16'h0, freq_out};
        default: rdata_q <= '0;
      endcase
    end
  end
  assign reg_rdata_out = rdata_q;
endmodule : jdb_ctrl
`default_nettype wire

/* design/jdb_delay_timer.sv */
// Brake delay timer counting in 0.1 s units.
`default_nettype none
module jdb_delay_timer
  import jdb_pkg::*;
#(
  parameter int UNIT_CYC = JDB_DELAY_UNIT_CYC
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic start_in,
  input wire logic [7:0] units_in,
  output logic busy_out,
  output logic done_out
);
  localparam int PW = $clog2(UNIT_CYC + 1);
  logic [PW-1:0] pre_q;
  logic [7:0] left_q;
  logic busy_q;
  logic done_q;

  // Restart on start; one done pulse when the count runs out
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pre_q <= '0;
      left_q <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (start_in) begin
        pre_q <= '0;
        left_q <= units_in;
        busy_q <= (units_in != 8'h00);
        done_q <= (units_in == 8'h00);
      end else if (busy_q) begin
        if (pre_q == PW'(UNIT_CYC - 1)) begin
          pre_q <= '0;
          left_q <= left_q - 8'h01;
          if (left_q == 8'h01) begin
            busy_q <= 1'b0;
            done_q <= 1'b1;
          end
        end else begin
          pre_q <= pre_q + 1'b1;
        end
      end
    end
  end

  assign busy_out = busy_q;
  assign done_out = done_q;
endmodule : jdb_delay_timer
`default_nettype wire

/* design/jdb_input_filter.sv */
// Two-flop synchroniser and debounce for one terminal.
`default_nettype none
module jdb_input_filter
  import jdb_pkg::*;
#(
  parameter int SETTLE_CYC = JDB_DEBOUNCE_CYC
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic pin_in,
  output logic level_out
);
  localparam int CW = $clog2(SETTLE_CYC + 1);
  logic meta_q;
  logic sync_q;
  logic [CW-1:0] cnt_q;
  logic level_q;

  // Two flops; only the second one is read onward
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
    end
  end

  // Level accepted only after staying put for the settle time; contact bounce is swallowed
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cnt_q <= '0;
      level_q <= 1'b0;
    end else if (sync_q == level_q) begin
      cnt_q <= '0;
    end else if (cnt_q == CW'(SETTLE_CYC - 1)) begin
      cnt_q <= '0;
      level_q <= sync_q;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  assign level_out = level_q;
endmodule : jdb_input_filter
`default_nettype wire

/* design/jdb_pkg.sv */
// Package for the jog and DC brake input logic: constants and carrier types.
`default_nettype none
package jdb_pkg;
  // Register offsets (word addresses on the plain register port)
  localparam logic [3:0] JDB_REG_CTRL = 4'h0;
  localparam logic [3:0] JDB_REG_JOG_FREQ = 4'h1;
  localparam logic [3:0] JDB_REG_START_FREQ = 4'h2;
  localparam logic [3:0] JDB_REG_BRK_DELAY = 4'h3;
  localparam logic [3:0] JDB_REG_BRK_FORCE = 4'h4;
  localparam logic [3:0] JDB_REG_STATUS = 4'h5;
  localparam logic [3:0] JDB_REG_IRQ_STAT = 4'h6;
  localparam logic [3:0] JDB_REG_IRQ_MASK = 4'h7;
  localparam logic [3:0] JDB_REG_TERM_FUNC = 4'h8;
  localparam logic [3:0] JDB_REG_RUN_FREQ = 4'h9;
  localparam logic [3:0] JDB_REG_OUT_FREQ = 4'ha;

  // Frequencies in 0.01 Hz units
  localparam logic [15:0] JDB_JOG_MAX_FREQ = 16'h03e8; // 10.00 Hz
  localparam logic [15:0] JDB_ZERO_FREQ = 16'h0000;
  // Unramped step that the output stage survives
  localparam logic [15:0] JDB_STEP_TRIP_FREQ = 16'h0320; // 8.00 Hz
  localparam logic [15:0] JDB_RAMP_STEP = 16'h0001;

  // Brake delay 0.0 to 5.0 s in 0.1 s units; force 0 to 100 percent
  localparam logic [7:0] JDB_BRK_DELAY_MAX = 8'h32;
  localparam logic [7:0] JDB_BRK_FORCE_MAX = 8'h64;
  localparam int JDB_CLK_HZ = 25000000;
  localparam int JDB_DELAY_UNIT_MS = 100;
  localparam int JDB_DELAY_UNIT_CYC = JDB_CLK_HZ / 1000 * JDB_DELAY_UNIT_MS;

  // Input terminal function codes
  localparam logic [7:0] JDB_FUNC_JOG = 8'h06;
  localparam logic [7:0] JDB_FUNC_BRAKE = 8'h07;
  localparam int JDB_NUM_TERM = 5;

  // Control register fields
  localparam int JDB_CTRL_MODE_LSB = 0;
  localparam int JDB_CTRL_KEYPAD_BIT = 4;
  localparam int JDB_CTRL_KEYRUN_BIT = 5;

  // Interrupt events
  localparam int JDB_EV_TRIP = 0;
  localparam int JDB_EV_JOG_REJECT = 1;
  localparam int JDB_EV_ORDER_OFF = 2;
  localparam int JDB_EV_BRAKE = 3;
  localparam int JDB_NUM_EV = 4;

  // Debounce settle time
  localparam int JDB_DEBOUNCE_US = 1000;
  localparam int JDB_DEBOUNCE_CYC = JDB_CLK_HZ / 1000000 * JDB_DEBOUNCE_US;

  // Jog mode codes
  typedef enum logic [2:0] {
    JDB_JM_IGN_COAST = 3'b000,
    JDB_JM_IGN_DECEL = 3'b001,
    JDB_JM_IGN_BRAKE = 3'b010,
    JDB_JM_INT_COAST = 3'b011,
    JDB_JM_INT_DECEL = 3'b100,
    JDB_JM_INT_BRAKE = 3'b101
  } jdb_jog_mode_t;

  // Drive output state
  typedef enum logic [2:0] {
    JDB_ST_IDLE = 3'b000,
    JDB_ST_RUN = 3'b001,
    JDB_ST_JOG = 3'b010,
    JDB_ST_COAST = 3'b011,
    JDB_ST_DECEL = 3'b100,
    JDB_ST_BRAKE = 3'b101,
    JDB_ST_OFF = 3'b110
  } jdb_state_t;

  // Drive command bundle leaving the block
  typedef struct packed {
    logic output_on;
    logic brake_on;
    logic [7:0] brake_force;
    logic [15:0] freq;
    logic trip;
  } jdb_drive_t;

  // Register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } jdb_bus_req_t;
endpackage : jdb_pkg
`default_nettype wire

/* test/jdb_ctrl_asserts.sv */
// Port checker for the jog and brake block.
`default_nettype none
module jdb_ctrl_asserts
  import jdb_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [31:0] reg_rdata_out,
  input wire logic output_on_out,
  input wire logic brake_on_out,
  input wire logic [7:0] brake_force_out,
  input wire logic [15:0] freq_out,
  input wire logic trip_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  logic clr;
  // Trip clear by software
  assign clr = reg_wr_in && reg_addr_in == JDB_REG_STATUS && reg_wdata_in[0];
  a_trip_quiet: assert property (trip_out |-> !output_on_out && !brake_on_out && freq_out == 16'h0000)
    else $error("output live in trip");
  a_trip_sticky: assert property (trip_out && !clr |=> trip_out) else $error("trip left without clear");
  a_rd_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0) else $error("stray read data");
  a_unmapped_rd: assert property ($past(reg_rd_in) && $past(reg_addr_in) > JDB_REG_OUT_FREQ |-> reg_rdata_out == 32'h0)
    else $error("unmapped read not zero");
  a_delay_range: assert property ($past(reg_rd_in) && $past(reg_addr_in) == JDB_REG_BRK_DELAY |->
    reg_rdata_out <= 32'h32) else $error("brake delay above range");
  a_force_range: assert property ($past(reg_rd_in) && $past(reg_addr_in) == JDB_REG_BRK_FORCE |->
    reg_rdata_out <= 32'h64) else $error("force setting above range");
  a_force_out: assert property (brake_force_out <= JDB_BRK_FORCE_MAX)
    else $error("force output above range");
  a_jog_step: assert property (freq_out > $past(freq_out) + 16'h0001 |->
    freq_out <= JDB_JOG_MAX_FREQ && output_on_out) else $error("step above jog limit");
endmodule : jdb_ctrl_asserts
bind jdb_ctrl jdb_ctrl_asserts jdb_ctrl_asserts_i (.clk_in, .rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
  .reg_rd_in, .reg_rdata_out, .output_on_out, .brake_on_out, .brake_force_out, .freq_out, .trip_out);
`default_nettype wire

/* test/jdb_sw_model.sv */
// Switch bank driving the run and function terminals.
`default_nettype none
module jdb_sw_model (
  input wire logic clk_in,
  input wire logic [3:0] req_in,
  output logic fwd_out,
  output logic rev_out,
  output logic [4:0] term_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] r1_q = 4'h0, r2_q = 4'h0, p_q = 4'h0;
  // Each change bounces once, to exercise the filter
  always @(posedge clk_in) begin
    r1_q <= req_in;
    r2_q <= r1_q;
    p_q <= ((req_in ^ r1_q) & req_in) | (~(req_in ^ r1_q) & r2_q);
  end
  // Jog on terminal 0, brake on 1, rest pulled down
  assign fwd_out = p_q[0];
  assign rev_out = p_q[1];
  assign term_out = {3'h0, p_q[3], p_q[2]};
endmodule : jdb_sw_model
`default_nettype wire

/* test/tb_top.sv */
// Self-checking bench for the jog and brake block.
`default_nettype none
module tb_top;
  import jdb_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [3:0] a; logic [31:0] d, e;} jdb_tb_row_t;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic forward_run_input_in, reverse_run_input_in, irq_out, output_on_out, brake_on_out, reverse_out, trip_out;
  logic reg_wr_in = 1'b0, reg_rd_in = 1'b0;
  logic [4:0] term_in;
  logic [3:0] reg_addr_in = 4'h0, sw = 4'h0;
  logic [31:0] reg_wdata_in = 32'h0;
  logic [31:0] reg_rdata_out, rv;
  logic [7:0] brake_force_out;
  logic [15:0] freq_out;
  logic s_b, s_d;
  int mismatches = 0, n_tests = 0;
  int i, m, cnt;
  // Rows: address, data written, value read back
  jdb_tb_row_t rows [8] = '{'{JDB_REG_CTRL, 32'h7, 32'h5}, '{JDB_REG_BRK_DELAY, 32'hff, 32'h32},
    '{JDB_REG_BRK_FORCE, 32'hff, 32'h64}, '{JDB_REG_JOG_FREQ, 32'h1234, 32'h1234},
    '{JDB_REG_START_FREQ, 32'h64, 32'h64}, '{JDB_REG_IRQ_MASK, 32'hf, 32'hf},
    '{JDB_REG_TERM_FUNC, 32'h706, 32'h706}, '{4'hb, 32'h5a, 32'h0}};
  // Refused jogs: mode and jog frequency
  logic [31:0] rj_m [3] = '{32'h0, 32'h3, 32'h3};
  logic [31:0] rj_f [3] = '{32'h258, 32'h0, 32'h32};
  always #20 clk_in = ~clk_in;
  jdb_ctrl #(.DEBOUNCE_CYC(4), .DELAY_UNIT_CYC(5)) jdb_ctrl_i (.clk_in, .rst_in, .forward_run_input_in,
    .reverse_run_input_in, .term_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
    .irq_out, .output_on_out, .brake_on_out, .brake_force_out, .freq_out, .reverse_out, .trip_out);
  jdb_sw_model jdb_sw_model_i (.clk_in, .req_in(sw), .fwd_out(forward_run_input_in),
    .rev_out(reverse_run_input_in), .term_out(term_in));
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // A failed wait ends the run; the rest would cascade
  task automatic wchk(input logic [31:0] got, input logic [31:0] exp);
    chk(got, exp);
    if (got !== exp) conclude();
  endtask : wchk
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : tick
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1 rv = reg_rdata_out;
  endtask : rd
  task automatic sw_set(input logic [3:0] v);
    @(posedge clk_in);
    sw <= v;
  endtask : sw_set
  task automatic wf(input logic [15:0] f);
    for (cnt = 0; cnt < 300 && freq_out !== f; cnt++) tick(1);
    wchk(freq_out, f);
  endtask : wf
  // Mid-run reset and setup; terminal 0 jogs, 1 brakes
  task automatic cfg(input logic [31:0] ctrl, input logic [31:0] jf);
    sw <= 4'h0;
    rst_in <= 1'b1;
    tick(3);
    rst_in <= 1'b0;
    wr(JDB_REG_TERM_FUNC, 32'h706);
    wr(JDB_REG_BRK_DELAY, 32'h2);
    wr(JDB_REG_BRK_FORCE, 32'h40);
    wr(JDB_REG_JOG_FREQ, jf);
    wr(JDB_REG_START_FREQ, 32'h64);
    wr(JDB_REG_RUN_FREQ, 32'h20);
    wr(JDB_REG_IRQ_MASK, 32'hf);
    wr(JDB_REG_CTRL, ctrl);
    tick(8);
  endtask : cfg
  initial begin
    tick(12);
    rst_in <= 1'b0;
    tick(1);
    chk(irq_out, 1'b0);
    rd(JDB_REG_STATUS);
    chk(rv, 32'h0);
    for (i = 0; i < 8; i++) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a);
      chk(rv, rows[i].e);
    end
    // Jog interrupts a run, ends by coast, ramp or brake
    for (m = 3; m < 6; m++) begin
      cfg(m, 32'h258);
      sw_set(4'h1);
      wf(16'h20);
      sw_set(4'h5);
      for (cnt = 0; cnt < 40 && freq_out === 16'h20; cnt++) tick(1);
      chk(freq_out, 16'h258);
      sw_set(4'h0);
      {s_b, s_d} = 2'b00;
      repeat (40) begin
        tick(1);
        s_b |= brake_on_out;
        s_d |= output_on_out && freq_out < 16'h258 && freq_out != 16'h0;
      end
      chk(s_b, m == 5);
      chk(s_d, m == 4);
    end
    // Refused: ignored while running, zero, below start
    for (i = 0; i < 3; i++) begin
      cfg(rj_m[i], rj_f[i]);
      sw_set(4'h1);
      wf(16'h20);
      sw_set(4'h5);
      tick(20);
      chk(freq_out, 16'h20);
      rd(JDB_REG_IRQ_STAT);
      chk(rv[1], 1'b1);
    end
    // Jog before direction: output off; irq mask and clear
    cfg(32'h3, 32'h258);
    sw_set(4'h4);
    tick(12);
    sw_set(4'h5);
    tick(20);
    chk(output_on_out, 1'b0);
    rd(JDB_REG_IRQ_STAT);
    chk(rv[2], 1'b1);
    chk(irq_out, 1'b1);
    sw_set(4'h0);
    wr(JDB_REG_IRQ_MASK, 32'h0);
    tick(1);
    chk(irq_out, 1'b0);
    wr(JDB_REG_IRQ_STAT, 32'hf);
    wr(JDB_REG_IRQ_MASK, 32'hf);
    tick(1);
    chk(irq_out, 1'b0);
    // Oversized jog step trips until cleared
    cfg(32'h3, 32'hfa0);
    sw_set(4'h1);
    wf(16'h20);
    sw_set(4'h5);
    for (cnt = 0; cnt < 40 && trip_out !== 1'b1; cnt++) tick(1);
    wchk(trip_out, 1'b1);
    chk(irq_out, 1'b1);
    sw_set(4'h0);
    tick(20);
    chk(trip_out, 1'b1);
    wr(JDB_REG_STATUS, 32'h1);
    tick(1);
    chk(trip_out, 1'b0);
    // Reverse run: glitch ignored, brake, ramp back
    cfg(32'h3, 32'h258);
    sw_set(4'h2);
    wf(16'h20);
    chk(reverse_out, 1'b1);
    sw_set(4'ha);
    sw_set(4'h2);
    tick(20);
    chk(brake_on_out, 1'b0);
    sw_set(4'ha);
    for (cnt = 0; cnt < 40 && brake_on_out !== 1'b1; cnt++) tick(1);
    wchk(brake_on_out, 1'b1);
    chk(brake_force_out, 8'h40);
    sw_set(4'h2);
    wf(16'h20);
    chk(output_on_out, 1'b1);
    // Keypad run: coast, brake, stay off
    cfg(32'h33, 32'h258);
    wf(16'h20);
    sw_set(4'h8);
    for (cnt = 0; cnt < 40 && output_on_out === 1'b1; cnt++) tick(1);
    for (cnt = 0; cnt < 40 && brake_on_out !== 1'b1; cnt++) tick(1);
    chk(cnt inside {[8:12]}, 1'b1);
    sw_set(4'h0);
    tick(20);
    chk({output_on_out, brake_on_out}, 2'b00);
    conclude();
  end
endmodule : tb_top
`default_nettype wire
